/* File: design/itdm_dpram.sv */
// Dual-port descriptor store with byte write enables
`timescale 1ns/100ps
module itdm_dpram import itdm_pkg::*; (
    // Clock
    input wire logic clk_i,
    // Software port
    input wire logic [6:0] a_addr_i,
    input wire logic [3:0] a_we_i,
    input wire logic [31:0] a_wdat_i,
    output logic [31:0] a_q_o,
    // Engine port
    input wire logic [6:0] b_addr_i,
    input wire logic [3:0] b_we_i,
    input wire logic [31:0] b_wdat_i,
    output logic [31:0] b_q_o
);
    logic [31:0] mem [RAM_WORDS];

    // Engine write wins a same-word collision
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 4; i++) begin
            if (a_we_i[i]) mem[a_addr_i][8*i +: 8] <= a_wdat_i[8*i +: 8];
            if (b_we_i[i]) mem[b_addr_i][8*i +: 8] <= b_wdat_i[8*i +: 8];
        end
        a_q_o <= mem[a_addr_i];
        b_q_o <= mem[b_addr_i];
    end

endmodule : itdm_dpram

/* File: design/itdm_engine.sv */
// Interrupt triggered data mover: activation, descriptors, transfer, bus
//
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
// How it works
// - Normal mode moves one unit per activation
// - Repeat mode reloads count, rewinds repeating address
// - Block mode moves one whole block per activation
// - Activation runs the descriptor of its vector
// - Vector 0 to 95 selects the descriptor
// - Chain enable runs next descriptor at once
// - First descriptor without chain ends the activation
module itdm_engine import itdm_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire itdm_wb_req_type wb_i,
    output itdm_wb_rsp_type wb_o,
    // Activation from the interrupt router
    input wire logic act_req_i,
    input wire logic [6:0] act_vec_i,
    output logic act_ack_o,
    // Interrupt passed on to the processor
    output logic cpu_irq_o,
    output logic [6:0] cpu_irq_vec_o,
    // Memory master
    output itdm_mem_req_type mem_o,
    input wire itdm_mem_rsp_type mem_i,
    // Status
    output logic busy_o
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_LOAD, ST_READ, ST_WRITE, ST_FIN, ST_STORE, ST_DONE
    } itdm_state_type;

    itdm_state_type state_reg, state_next;
    logic [6:0] vec_reg, vec_next;
    logic [4:0] idx_reg, idx_next;
    logic [2:0] ld_reg, ld_next;
    logic [31:0] mode_reg, mode_next, src_reg, src_next, dst_reg, dst_next;
    logic [15:0] cnt_reg, cnt_next, blk_reg, blk_next;
    logic [15:0] rd_left_reg, rd_left_next, wr_left_reg, wr_left_next;
    logic pend_reg, pend_next, ack_reg, ack_next, irq_reg, irq_next;
    logic busy_reg, busy_next;
    itdm_mem_req_type mem_reg, mem_next;
    logic [4:0] vec_tab [VEC_NUM];
    logic [1:0] mode_code, size;
    logic [15:0] cnt_dec;
    logic [6:0] ram_b_addr;
    logic [3:0] ram_b_we;
    logic [31:0] ram_b_wdat, ram_b_q, ram_a_q;
    logic push_valid, push_ready, pop_valid, pop_ready;
    logic [31:0] push_data, pop_data;
    logic ctrl_en_reg, ctrl_en_next, wb_stage_reg, wb_stage_next;
    logic wb_ack_reg, wb_ack_next, wb_hit, vec_we, vec_hit, desc_hit;
    logic [31:0] wb_rdat_reg, wb_rdat_next;
    logic [3:0] ram_a_we;

    assign mode_code = mode_reg[MODE_LSB +: 2];
    assign size = mode_reg[SIZE_LSB +: 2];
    assign cnt_dec = cnt_reg - 16'h1;

    itdm_dpram u_ram (
        .clk_i(clk_i),
        .a_addr_i(wb_i.adr[8:2]),
        .a_we_i(ram_a_we),
        .a_wdat_i(wb_i.dat),
        .a_q_o(ram_a_q),
        .b_addr_i(ram_b_addr),
        .b_we_i(ram_b_we),
        .b_wdat_i(ram_b_wdat),
        .b_q_o(ram_b_q)
    );

    itdm_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(push_valid),
        .in_ready_o(push_ready),
        .in_data_i(push_data),
        .out_valid_o(pop_valid),
        .out_ready_i(pop_ready),
        .out_data_o(pop_data)
    );

    // Transfer engine
    always_comb begin
        state_next = state_reg;
        vec_next = vec_reg;
        idx_next = idx_reg;
        ld_next = ld_reg;
        mode_next = mode_reg;
        src_next = src_reg;
        dst_next = dst_reg;
        cnt_next = cnt_reg;
        blk_next = blk_reg;
        rd_left_next = rd_left_reg;
        wr_left_next = wr_left_reg;
        pend_next = pend_reg;
        mem_next = mem_reg;
        ack_next = 1'h0;
        irq_next = 1'h0;
        ram_b_addr = {idx_reg, ld_reg[1:0]};
        ram_b_we = 4'h0;
        ram_b_wdat = 32'h0;
        push_valid = 1'h0;
        push_data = 32'h0;
        pop_ready = 1'h0;
        unique case (state_reg)
            ST_IDLE: begin
                if (act_req_i && !ack_reg && ctrl_en_reg) begin
                    vec_next = act_vec_i;
                    pend_next = 1'h0;
                    if (act_vec_i < VEC_NUM) begin
                        idx_next = vec_tab[act_vec_i];
                        ld_next = 3'h0;
                        state_next = ST_LOAD;
                    end else begin
                        state_next = ST_DONE;
                    end
                end
            end
            ST_LOAD: begin
                ld_next = ld_reg + 3'h1;
                case (ld_reg)
                    3'h1: mode_next = ram_b_q;
                    3'h2: src_next = ram_b_q;
                    3'h3: dst_next = ram_b_q;
                    3'h4: begin
                        cnt_next = ram_b_q[CNT_LSB +: 16];
                        blk_next = ram_b_q[BLK_LSB +: 16];
                        if (mode_code == MODE_BLOCK) begin
                            rd_left_next = ram_b_q[BLK_LSB +: 16];
                            wr_left_next = ram_b_q[BLK_LSB +: 16];
                        end else begin
                            rd_left_next = 16'h1;
                            wr_left_next = 16'h1;
                        end
                        state_next = ST_READ;
                    end
                    default: ;
                endcase
            end
            ST_READ: begin
                if (mem_reg.cyc) begin
                    if (mem_i.ack) begin
                        mem_next.cyc = 1'h0;
                        push_valid = 1'h1;
                        push_data = itdm_extract(size, src_reg[1:0], mem_i.dat);
                        if (mode_reg[SRC_INC_BIT]) begin
                            src_next = src_reg + itdm_step(size);
                        end
                        rd_left_next = rd_left_reg - 16'h1;
                    end
                end else if (rd_left_reg == 16'h0 || !push_ready) begin
                    state_next = ST_WRITE;
                end else begin
                    mem_next.cyc = 1'h1;
                    mem_next.we = 1'h0;
                    mem_next.adr = {src_reg[31:2], 2'h0};
                    mem_next.dat = 32'h0;
                    mem_next.sel = itdm_sel(size, src_reg[1:0]);
                end
            end
            ST_WRITE: begin
                if (mem_reg.cyc) begin
                    if (mem_i.ack) begin
                        mem_next.cyc = 1'h0;
                        if (mode_reg[DST_INC_BIT]) begin
                            dst_next = dst_reg + itdm_step(size);
                        end
                        wr_left_next = wr_left_reg - 16'h1;
                    end
                end else if (pop_valid) begin
                    pop_ready = 1'h1;
                    mem_next.cyc = 1'h1;
                    mem_next.we = 1'h1;
                    mem_next.adr = {dst_reg[31:2], 2'h0};
                    mem_next.dat = itdm_place(size, pop_data);
                    mem_next.sel = itdm_sel(size, dst_reg[1:0]);
                end else if (wr_left_reg == 16'h0) begin
                    state_next = ST_FIN;
                end else begin
                    state_next = ST_READ;
                end
            end
            ST_FIN: begin
                cnt_next = cnt_dec;
                if (mode_code == MODE_REPEAT && cnt_dec == 16'h0) begin
                    cnt_next = blk_reg;
                    if (mode_reg[RPT_DST_BIT]) begin
                        if (mode_reg[DST_INC_BIT]) begin
                            dst_next = itdm_rewind(dst_reg, blk_reg, size);
                        end
                    end else if (mode_reg[SRC_INC_BIT]) begin
                        src_next = itdm_rewind(src_reg, blk_reg, size);
                    end
                end
                if (!mode_reg[IRQ_END_BIT] ||
                    (mode_code != MODE_REPEAT && cnt_dec == 16'h0)) begin
                    pend_next = 1'h1;
                end
                ld_next = 3'h0;
                state_next = ST_STORE;
            end
            ST_STORE: begin
                ram_b_addr = {idx_reg, ld_reg[1:0] + DW_SRC};
                ram_b_we = 4'hF;
                ram_b_wdat = (ld_reg == 3'h0) ? src_reg :
                             (ld_reg == 3'h1) ? dst_reg : {blk_reg, cnt_reg};
                ld_next = ld_reg + 3'h1;
                if (ld_reg == 3'h2) begin
                    ld_next = 3'h0;
                    if (mode_reg[CHAIN_BIT]) begin
                        idx_next = idx_reg + 5'h1;
                        state_next = ST_LOAD;
                    end else begin
                        state_next = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                ack_next = 1'h1;
                irq_next = pend_reg;
                state_next = ST_IDLE;
            end
        endcase
        busy_next = (state_next != ST_IDLE);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            vec_reg <= '0;
            idx_reg <= '0;
            ld_reg <= '0;
            mode_reg <= '0;
            src_reg <= '0;
            dst_reg <= '0;
            cnt_reg <= '0;
            blk_reg <= '0;
            rd_left_reg <= '0;
            wr_left_reg <= '0;
            pend_reg <= 1'h0;
            ack_reg <= 1'h0;
            irq_reg <= 1'h0;
            busy_reg <= 1'h0;
            mem_reg <= '0;
        end else begin
            state_reg <= state_next;
            vec_reg <= vec_next;
            idx_reg <= idx_next;
            ld_reg <= ld_next;
            mode_reg <= mode_next;
            src_reg <= src_next;
            dst_reg <= dst_next;
            cnt_reg <= cnt_next;
            blk_reg <= blk_next;
            rd_left_reg <= rd_left_next;
            wr_left_reg <= wr_left_next;
            pend_reg <= pend_next;
            ack_reg <= ack_next;
            irq_reg <= irq_next;
            busy_reg <= busy_next;
            mem_reg <= mem_next;
        end
    end

    // Wishbone slave, answers two cycles after the request appears
    always_comb begin
        wb_hit = wb_i.cyc && wb_i.stb && !wb_ack_reg;
        vec_hit = (wb_i.adr[11:9] == VEC_BASE[11:9]) &&
                  (wb_i.adr[8:2] < VEC_NUM);
        desc_hit = (wb_i.adr[11:9] == DESC_BASE[11:9]);
        wb_stage_next = wb_hit && !wb_stage_reg;
        wb_ack_next = wb_hit && wb_stage_reg;
        wb_rdat_next = wb_rdat_reg;
        ctrl_en_next = ctrl_en_reg;
        vec_we = 1'h0;
        ram_a_we = 4'h0;
        if (wb_ack_next && wb_i.we) begin
            if (wb_i.adr[11:0] == CTRL_OFS && wb_i.sel[0]) begin
                ctrl_en_next = wb_i.dat[CTRL_EN_BIT];
            end
            vec_we = vec_hit && wb_i.sel[0];
            ram_a_we = desc_hit ? wb_i.sel : 4'h0;
        end else if (wb_ack_next) begin
            wb_rdat_next = 32'h0;
            if (wb_i.adr[11:0] == CTRL_OFS) begin
                wb_rdat_next[CTRL_EN_BIT] = ctrl_en_reg;
            end else if (wb_i.adr[11:0] == STAT_OFS) begin
                wb_rdat_next[STAT_BUSY_BIT] = busy_reg;
                wb_rdat_next[STAT_VEC_LSB +: 7] = vec_reg;
                wb_rdat_next[STAT_IDX_LSB +: 5] = idx_reg;
            end else if (vec_hit) begin
                wb_rdat_next[4:0] = vec_tab[wb_i.adr[8:2]];
            end else if (desc_hit) begin
                wb_rdat_next = ram_a_q;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_en_reg <= CTRL_EN_RST;
            wb_stage_reg <= 1'h0;
            wb_ack_reg <= 1'h0;
            wb_rdat_reg <= '0;
        end else begin
            ctrl_en_reg <= ctrl_en_next;
            wb_stage_reg <= wb_stage_next;
            wb_ack_reg <= wb_ack_next;
            wb_rdat_reg <= wb_rdat_next;
        end
    end

    // Vector to descriptor table
    always_ff @(posedge clk_i) begin
        if (vec_we) vec_tab[wb_i.adr[8:2]] <= wb_i.dat[4:0];
    end

    assign wb_o.ack = wb_ack_reg;
    assign wb_o.dat = wb_rdat_reg;
    assign act_ack_o = ack_reg;
    assign cpu_irq_o = irq_reg;
    assign cpu_irq_vec_o = vec_reg;
    assign mem_o = mem_reg;
    assign busy_o = busy_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_wb_new;
        wb_i.cyc && wb_i.stb && !wb_ack_reg && !wb_stage_reg;
    endsequence
    sequence s_loaded;
        state_reg == ST_LOAD && ld_reg == 3'h4;
    endsequence
    sequence s_rpt_wrap;
        state_reg == ST_FIN && mode_code == MODE_REPEAT && cnt_reg == 16'h1;
    endsequence
    sequence s_accept;
        state_reg == ST_IDLE && act_req_i && !ack_reg && ctrl_en_reg;
    endsequence
    sequence s_last_store;
        state_reg == ST_STORE && ld_reg == 3'h2;
    endsequence

    a_wb_ack_timing: assert property (s_wb_new |-> ##2 wb_o.ack)
        else $error("bus answer not two cycles after request");
    a_normal_single: assert property (s_loaded ##0 (mode_code == MODE_NORMAL)
        |=> rd_left_reg == 16'h1 && wr_left_reg == 16'h1)
        else $error("normal mode does not move one unit");
    a_block_length: assert property (s_loaded ##0 (mode_code == MODE_BLOCK)
        |=> rd_left_reg == $past(ram_b_q[31:16]))
        else $error("block mode length wrong");
    a_repeat_reload: assert property (s_rpt_wrap
        |=> cnt_reg == $past(blk_reg))
        else $error("repeat count not reloaded");
    a_repeat_rewind: assert property (s_rpt_wrap ##0
        (mode_reg[RPT_DST_BIT] && mode_reg[DST_INC_BIT])
        |=> dst_reg == itdm_rewind($past(dst_reg), $past(blk_reg), $past(size)))
        else $error("repeat address not returned to start");
    a_vector_lookup: assert property (s_accept ##0 (act_vec_i < VEC_NUM)
        |=> state_reg == ST_LOAD && idx_reg == vec_tab[$past(act_vec_i)])
        else $error("activation did not select its descriptor");
    a_vector_range: assert property (s_accept ##0 (act_vec_i >= VEC_NUM)
        |=> state_reg == ST_DONE)
        else $error("vector above range was not refused");
    a_chain_next: assert property (s_last_store ##0 mode_reg[CHAIN_BIT]
        |=> state_reg == ST_LOAD && idx_reg == $past(idx_reg) + 5'h1)
        else $error("chain did not go to next descriptor");
    a_chain_stop: assert property (s_last_store ##0 !mode_reg[CHAIN_BIT]
        |=> state_reg == ST_DONE ##1 act_ack_o)
        else $error("chain did not end");
    a_end_irq: assert property (state_reg == ST_FIN &&
        mode_code != MODE_REPEAT && cnt_reg == 16'h1 ##3 s_last_store
        ##0 !mode_reg[CHAIN_BIT] |-> ##2 cpu_irq_o)
        else $error("end of count not passed to processor");
    a_unit_lanes: assert property (mem_o.cyc && !$past(mem_o.cyc)
        |-> mem_o.sel == itdm_sel(size, mem_o.we ? dst_reg[1:0] : src_reg[1:0]))
        else $error("byte lanes do not match unit size");
    a_mem_hold: assert property (mem_o.cyc && !mem_i.ack
        |=> mem_o.cyc && $stable(mem_o.adr))
        else $error("memory request dropped before answer");

endmodule : itdm_engine

/* File: design/itdm_fifo.sv */
// Parameterised FIFO between the read and write phases of the mover
`timescale 1ns/100ps
module itdm_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
    logic push, pop;

    // Pointers carry one extra bit to tell full from empty
    always_comb begin
        in_ready_o = !((wr_reg[AW] != rd_reg[AW]) &&
                       (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
        out_valid_o = (wr_reg != rd_reg);
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        wr_next = push ? wr_reg + {{AW{1'h0}}, 1'h1} : wr_reg;
        rd_next = pop ? rd_reg + {{AW{1'h0}}, 1'h1} : rd_reg;
        out_data_o = mem[rd_reg[AW-1:0]];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
        if (push) mem[wr_reg[AW-1:0]] <= in_data_i;
    end

endmodule : itdm_fifo

/* File: design/itdm_pkg.sv */
// Shared constants, types and helpers of the interrupt triggered data mover
package itdm_pkg;

    // Register map (low twelve address bits)
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    localparam logic [11:0] VEC_BASE = 12'h200;
    localparam logic [11:0] DESC_BASE = 12'h400;

    // Table sizes
    localparam logic [6:0] VEC_NUM = 7'h60;
    localparam int RAM_WORDS = 128;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_WIDTH = 32;

    // Control and status fields
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'h0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_VEC_LSB = 8;
    localparam int STAT_IDX_LSB = 16;

    // Descriptor mode and count word fields
    localparam int MODE_LSB = 0;
    localparam int SIZE_LSB = 2;
    localparam int SRC_INC_BIT = 4;
    localparam int DST_INC_BIT = 5;
    localparam int RPT_DST_BIT = 6;
    localparam int IRQ_END_BIT = 7;
    localparam int CHAIN_BIT = 8;
    localparam int CNT_LSB = 0;
    localparam int BLK_LSB = 16;

    // Descriptor word order
    localparam logic [1:0] DW_MODE = 2'h0;
    localparam logic [1:0] DW_SRC = 2'h1;

    // Mode and unit size codes
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_REPEAT = 2'h1;
    localparam logic [1:0] MODE_BLOCK = 2'h2;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
    } itdm_wb_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } itdm_wb_rsp_type;

    typedef struct packed {
        logic cyc;
        logic we;
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
    } itdm_mem_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } itdm_mem_rsp_type;

    function automatic logic [3:0] itdm_sel(input logic [1:0] sz,
                                            input logic [1:0] a);
        logic [3:0] s;
        s = 4'hF;
        if (sz == SIZE_BYTE) s = 4'h1 << a;
        else if (sz == SIZE_HALF) s = a[1] ? 4'hC : 4'h3;
        return s;
    endfunction : itdm_sel

    function automatic logic [31:0] itdm_extract(input logic [1:0] sz,
                                                 input logic [1:0] a,
                                                 input logic [31:0] w);
        logic [31:0] v;
        v = w >> {a, 3'h0};
        if (sz == SIZE_BYTE) v = {24'h000000, v[7:0]};
        else if (sz == SIZE_HALF) v = {16'h0000, v[15:0]};
        return v;
    endfunction : itdm_extract

    function automatic logic [31:0] itdm_place(input logic [1:0] sz,
                                               input logic [31:0] d);
        logic [31:0] v;
        v = d;
        if (sz == SIZE_BYTE) v = {4{d[7:0]}};
        else if (sz == SIZE_HALF) v = {2{d[15:0]}};
        return v;
    endfunction : itdm_place

    function automatic logic [31:0] itdm_step(input logic [1:0] sz);
        return 32'h1 << sz;
    endfunction : itdm_step

    function automatic logic [31:0] itdm_rewind(input logic [31:0] a,
                                                input logic [15:0] n,
                                                input logic [1:0] sz);
        return a - ({16'h0000, n} << sz);
    endfunction : itdm_rewind

endpackage : itdm_pkg

/* File: testbench/itdm_mem_model.sv */
// Memory model answering the mover's bus master after one wait cycle on every request
`timescale 1ns/100ps
module itdm_mem_model import itdm_pkg::*; (
    // Clock
    input wire logic clk_i,
    // Bus from the mover
    input wire itdm_mem_req_type req_i,
    output itdm_mem_rsp_type rsp_o
);
    logic [31:0] mem [0:63];
    logic [1:0] wait_reg;
    initial begin
        rsp_o = '0;
        wait_reg = 2'h0;
    end
    always @(posedge clk_i) begin
        rsp_o.ack <= 1'b0;
        rsp_o.dat <= ~rsp_o.dat;
        if (req_i.cyc && !rsp_o.ack) begin
            wait_reg <= wait_reg + 2'h1;
            if (wait_reg[0]) begin
                rsp_o.ack <= 1'b1;
                rsp_o.dat <= mem[req_i.adr[7:2]];
                for (int i = 0; i < 4; i++) begin
                    if (req_i.we && req_i.sel[i])
                        mem[req_i.adr[7:2]][8*i+:8] <= req_i.dat[8*i+:8];
                end
            end
        end
    end
endmodule : itdm_mem_model

/* File: testbench/tb_top.sv */
// Testbench of the interrupt triggered data mover
`timescale 1ns/100ps
module tb_top import itdm_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    itdm_wb_req_type wb = '0;
    itdm_wb_rsp_type wb_o;
    logic act_req = 1'b0;
    logic [6:0] act_vec = 7'h00;
    logic act_ack, irq, busy, got_irq, got_busy;
    logic [6:0] irq_vec, got_vec;
    logic slot_on [96];
    logic [8:0] slot_src [96];
    itdm_mem_req_type mem_o;
    itdm_mem_rsp_type mem_i;
    logic [31:0] rd;
    int err_count = 0;
    int checked = 0;
    itdm_engine i_itdm_engine (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb),
        .wb_o(wb_o), .act_req_i(act_req), .act_vec_i(act_vec),
        .act_ack_o(act_ack), .cpu_irq_o(irq), .cpu_irq_vec_o(irq_vec),
        .mem_o(mem_o), .mem_i(mem_i), .busy_o(busy));
    itdm_mem_model i_itdm_mem_model (.clk_i(clk_i), .req_i(mem_o),
        .rsp_o(mem_i));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    function automatic logic [31:0] mw(input int i);
        return i_itdm_mem_model.mem[i];
    endfunction : mw
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb_go(input logic w, input logic [11:0] a,
                         input logic [31:0] d);
        wb <= '{1'b1, 1'b1, w, {20'h00000, a}, d, 4'hF};
        do begin
            @(posedge clk_i);
        end while (wb_o.ack !== 1'b1);
        rd = wb_o.dat;
        wb <= '0;
        @(posedge clk_i);
    endtask : wb_go
    task automatic act(input logic [6:0] v);
        act_req <= 1'b1;
        act_vec <= v;
        got_busy = 1'b0;
        do begin
            @(posedge clk_i);
            if (busy === 1'b1) got_busy = 1'b1;
        end while (act_ack !== 1'b1);
        got_irq = irq;
        got_vec = irq_vec;
        act_req <= 1'b0;
        @(posedge clk_i);
    endtask : act
    // Router: every enabled slot fed by this source activates the mover
    task automatic fire(input logic [8:0] s);
        for (int i = 0; i < 96; i++) begin
            if (slot_on[i] === 1'b1 && slot_src[i] == s) act(7'(i));
        end
    endtask : fire
    task automatic desc(input logic [4:0] d, input logic [31:0] m, s, t, c);
        logic [11:0] b;
        b = DESC_BASE + {3'h0, d, 4'h0};
        wb_go(1'b1, b, m);
        wb_go(1'b1, b + 12'h004, s);
        wb_go(1'b1, b + 12'h008, t);
        wb_go(1'b1, b + 12'h00C, c);
    endtask : desc
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        #100000;
        err_count++;
        end_of_test;
    end
    initial begin
        for (int i = 0; i < 64; i++)
            i_itdm_mem_model.mem[i] = 32'h10000000 + i;
        for (int i = 0; i < 96; i++) begin
            slot_on[i] = (i == 5 || i == 7 || i == 95);
            slot_src[i] = (i == 7) ? 9'h1A3 : (i == 95) ? 9'h040 : 9'h011;
        end
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb_go(1'b1, CTRL_OFS, 32'h00000001);
        wb_go(1'b0, CTRL_OFS, 32'h00000000);
        chk(rd, 32'h00000001);
        wb_go(1'b0, 12'h100, 32'h00000000);
        chk(rd, 32'h00000000);
        wb_go(1'b1, VEC_BASE + 12'h014, 32'h00000000);
        wb_go(1'b1, VEC_BASE + 12'h17C, 32'h00000001);
        wb_go(1'b1, VEC_BASE + 12'h01C, 32'h00000004);
        desc(5'h00, 32'h000000B8, 32'h00, 32'h80, 32'h00000002);
        desc(5'h01, 32'h0000013A, 32'h10, 32'h90, 32'h00030001);
        desc(5'h02, 32'h00000038, 32'h20, 32'hA0, 32'h00000001);
        desc(5'h03, 32'h00000038, 32'h24, 32'hA4, 32'h00000001);
        desc(5'h04, 32'h00000069, 32'h30, 32'hB0, 32'h00020002);
        fire(9'h011);
        chk({31'h0, got_busy}, 32'h00000001);
        chk(mw(32), 32'h10000000);
        chk(mw(33), 32'h10000021);
        chk({31'h0, got_irq}, 32'h0);
        fire(9'h011);
        chk(mw(33), 32'h10000001);
        chk({31'h0, got_irq}, 32'h1);
        chk({25'h0, got_vec}, 32'h00000005);
        wb_go(1'b0, STAT_OFS, 32'h00000000);
        chk(rd, 32'h00000500);
        fire(9'h040);
        for (int i = 0; i < 3; i++) chk(mw(36 + i), 32'h10000004 + i);
        chk(mw(40), 32'h10000008);
        chk(mw(41), 32'h10000029);
        wb_go(1'b0, STAT_OFS, 32'h00000000);
        chk(rd, 32'h00025F00);
        fire(9'h1A3);
        fire(9'h1A3);
        chk(mw(45), 32'h1000000C);
        i_itdm_mem_model.mem[12] = 32'hABCD0000;
        fire(9'h1A3);
        chk(mw(44), 32'hABCD0000);
        chk(mw(46), 32'h1000002E);
        chk({31'h0, got_irq}, 32'h1);
        wb_go(1'b0, DESC_BASE + 12'h048, 32'h00000000);
        chk(rd, 32'h000000B4);
        act(VEC_NUM);
        chk({31'h0, got_irq}, 32'h0);
        end_of_test;
    end
endmodule : tb_top
